//--- design/bsfm_top.sv
// module: brake sequencer and fault manager with its apb register file
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module bsfm_top
	import bsfm_pkg::*;
#(
	parameter int SPEED_W = 16
)(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hwEnablePin,
	input wire logic thermalSwitchPin,
	input wire logic shortDetectPin,
	input wire logic ampOverTempPin,
	input wire logic feedbackErrorPin,
	input wire logic overVoltagePin,
	input wire logic underVoltagePin,
	input wire logic currentSensePin,
	input wire logic hallMismatch,
	input wire logic commandLost,
	input wire logic i2tLimitReached,
	input wire logic followingError,
	input wire logic [SPEED_W-1:0] motorSpeed,
	output logic brake_output_pin,
	output logic pwmEnable,
	output logic decelActive,
	output logic decelUseAbort,
	output logic faultOutPin
);
	//--------------------------------------------------------------------
	// helper functions
	//--------------------------------------------------------------------

	// lowest set bit as a fault code; log priority goes to low indices
	function automatic logic [3:0] faultCode(input logic [NUM_FAULTS-1:0] v);
		logic [3:0] c;
		c = 4'hf;
		for (int i = NUM_FAULTS - 1; i >= 0; i--)
		begin
			if (v[i])
			begin
				c = 4'(i);
			end
		end
		return c;
	endfunction

	// magnitude of the signed enable delay
	function automatic logic [15:0] delayMag(input logic [15:0] v);
		logic [15:0] m;
		m = v[15] ? 16'(~v + 16'h0001) : v;
		return m;
	endfunction

	//--------------------------------------------------------------------
	// state
	//--------------------------------------------------------------------
	typedef struct packed {
		logic [NUM_PINS-1:0] sync1; // first synchroniser stage
		logic [NUM_PINS-1:0] sync2; // second stage, the only one logic reads
		bsfm_cfg_type cfg; // software settings
		bsfm_seq_type seq; // brake sequence state
		logic enPrev; // enable of last cycle, for edges
		logic hwEnPrev; // hardware enable of last cycle
		logic currSeen; // winding current seen in hold
		logic wireCond; // wiring check failed
		logic clearPulse; // one-cycle fault clear
		logic [NUM_FAULTS-1:0] activePrev; // faults of last cycle
		logic [3:0] lastCode; // newest logged fault type
		logic [7:0] logCount; // number of logged faults, saturating
		logic brake; // brake engaged
		logic pwm; // power stage on
		logic decel; // ramp to stop in progress
		logic abortRate; // decel uses the abort rate
		logic faultOut; // fault pin
		logic [31:0] prdata; // read data
		logic pready; // apb ready
		logic pslverr; // apb error
	} bsfm_top_state_type;

	bsfm_top_state_type s_q; // registered state
	bsfm_top_state_type s_d; // next state

	logic timerLoad; // restart the delay timer
	logic [TIMER_W-1:0] timerValue; // delay to load
	logic timerDone; // delay elapsed
	logic [NUM_FAULTS-1:0] faultCond; // raw fault conditions
	logic [NUM_FAULTS-1:0] latchMask; // effective latch enables
	logic [NUM_FAULTS-1:0] faultActive; // current fault flags

	//--------------------------------------------------------------------
	// submodules
	//--------------------------------------------------------------------

	// one timer is enough: the sequence never runs two delays at once
	bsfm_timer #(
		.W(TIMER_W)
	) u_timer (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.load(timerLoad),
		.loadValue(timerValue),
		.expired(timerDone)
	);

	bsfm_fault_latch #(
		.N(NUM_FAULTS)
	) u_faults (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.cond(faultCond),
		.latchEn(latchMask),
		.clearEvt(s_q.clearPulse),
		.active(faultActive)
	);

	//--------------------------------------------------------------------
	// fault conditions
	//--------------------------------------------------------------------

	// pins are read only after the second synchroniser stage
	always_comb
	begin
		faultCond = '0;
		faultCond[F_SHORT] = s_q.sync2[P_SHORT];
		faultCond[F_AMP_OT] = s_q.sync2[P_AMP_OT];
		faultCond[F_MOTOR_OT] = s_q.sync2[P_THERMAL];
		faultCond[F_OVER_V] = s_q.sync2[P_OVER_V];
		faultCond[F_UNDER_V] = s_q.sync2[P_UNDER_V];
		faultCond[F_FEEDBACK] = s_q.sync2[P_FEEDBACK];
		faultCond[F_PHASING] = hallMismatch && s_q.cfg.sineHall;
		faultCond[F_FOLLOW] = followingError;
		faultCond[F_CMD] = commandLost;
		faultCond[F_WIRING] = s_q.wireCond;
		faultCond[F_OVER_CUR] = i2tLimitReached && s_q.cfg.i2tEnable;
		// over-current is latched whatever software sets
		latchMask = s_q.cfg.latchEn | OVER_CUR_MASK;
	end

	//--------------------------------------------------------------------
	// next state
	//--------------------------------------------------------------------
	always_comb
	begin
		logic enable; // combined hardware and software enable
		logic enRise; // enable came on
		logic enFall; // enable went off
		logic apbWrite; // write completes this cycle
		logic [NUM_FAULTS-1:0] newFaults; // faults that just appeared
		logic seqPwm; // power stage as the sequence wants it
		enable = 1'b0;
		enRise = 1'b0;
		enFall = 1'b0;
		apbWrite = 1'b0;
		newFaults = '0;
		seqPwm = 1'b0;
		s_d = s_q;
		timerLoad = 1'b0;
		timerValue = '0;

		// two-stage synchroniser for every pin
		s_d.sync1 = {currentSensePin, underVoltagePin, overVoltagePin, feedbackErrorPin,
			ampOverTempPin, shortDetectPin, thermalSwitchPin, hwEnablePin};
		s_d.sync2 = s_q.sync1;

		enable = s_q.sync2[P_HW_EN] || s_q.cfg.swEnable;
		enRise = enable && !s_q.enPrev;
		enFall = !enable && s_q.enPrev;
		s_d.enPrev = enable;
		s_d.hwEnPrev = s_q.sync2[P_HW_EN];

		// ----------------------------------------------------------------
		// apb slave, zero wait states: ready rises for the access phase
		// ----------------------------------------------------------------
		s_d.clearPulse = 1'b0;
		s_d.pready = psel && !penable && !s_q.pready;
		apbWrite = psel && penable && pwrite && s_q.pready;
		if (psel && !penable && !s_q.pready)
		begin
			s_d.pslverr = 1'b0;
			s_d.prdata = '0;
			unique case (paddr)
				OFF_CTRL:
					s_d.prdata[6:0] = {s_q.cfg.enableClears, s_q.cfg.i2tEnable,
						s_q.cfg.sineHall, s_q.cfg.brakeUsed, s_q.cfg.posMode, 1'b0,
						s_q.cfg.swEnable};
				OFF_STOP_DLY: s_d.prdata[15:0] = s_q.cfg.stopDelay;
				OFF_RESP: s_d.prdata[15:0] = s_q.cfg.respTime;
				OFF_HOLD: s_d.prdata[15:0] = s_q.cfg.holdTime;
				OFF_EN_DLY: s_d.prdata[15:0] = s_q.cfg.enDelay;
				OFF_ACT_VEL: s_d.prdata[15:0] = s_q.cfg.actVel;
				OFF_LATCH: s_d.prdata[NUM_FAULTS-1:0] = s_q.cfg.latchEn;
				OFF_OUT_MASK: s_d.prdata[NUM_FAULTS-1:0] = s_q.cfg.outMask;
				OFF_STATUS:
					// status shows the block's own state
					s_d.prdata[23:0] = {s_q.decel, s_q.pwm, s_q.brake, 2'b00, s_q.seq,
						5'h00, faultActive};
				OFF_LOG: s_d.prdata[15:0] = {s_q.logCount, 4'h0, s_q.lastCode};
				default: s_d.pslverr = 1'b1; // unmapped address
			endcase
		end
		else if (s_q.pready)
		begin
			// answer stands for the access cycle only
			s_d.prdata = '0;
			s_d.pslverr = 1'b0;
		end
		if (apbWrite)
		begin
			unique case (paddr)
				OFF_CTRL:
				begin
					s_d.cfg.swEnable = pwdata[CTRL_SW_EN];
					s_d.clearPulse = pwdata[CTRL_CLEAR];
					s_d.cfg.posMode = pwdata[CTRL_POS_MODE];
					s_d.cfg.brakeUsed = pwdata[CTRL_BRAKE_USED];
					s_d.cfg.sineHall = pwdata[CTRL_SINE_HALL];
					s_d.cfg.i2tEnable = pwdata[CTRL_I2T_EN];
					s_d.cfg.enableClears = pwdata[CTRL_EN_CLEARS];
				end
				OFF_STOP_DLY: s_d.cfg.stopDelay = pwdata[15:0];
				OFF_RESP: s_d.cfg.respTime = pwdata[15:0];
				OFF_HOLD: s_d.cfg.holdTime = pwdata[15:0];
				OFF_EN_DLY: s_d.cfg.enDelay = pwdata[15:0];
				OFF_ACT_VEL: s_d.cfg.actVel = pwdata[15:0];
				OFF_LATCH: s_d.cfg.latchEn = pwdata[NUM_FAULTS-1:0];
				OFF_OUT_MASK: s_d.cfg.outMask = pwdata[NUM_FAULTS-1:0];
				default:
				begin
					// read-only and unmapped words ignore writes
				end
			endcase
		end

		// disable-then-enable of the hardware input clears when so configured
		if (s_q.cfg.enableClears && s_q.sync2[P_HW_EN] && !s_q.hwEnPrev)
		begin
			s_d.clearPulse = 1'b1;
		end

		// ----------------------------------------------------------------
		// brake sequence
		// ----------------------------------------------------------------
		unique case (s_q.seq)
			SEQ_OFF:
			begin
				s_d.brake = 1'b1;
				s_d.decel = 1'b0;
				if (enRise && s_q.cfg.brakeUsed)
				begin
					// wiring check: current on, brake still held
					s_d.seq = SEQ_HOLD;
					s_d.currSeen = 1'b0;
					s_d.wireCond = 1'b0; // fresh check, else the old fault cuts its own current
					timerLoad = 1'b1;
					timerValue = s_q.cfg.holdTime;
				end
				else if (enRise)
				begin
					// sign of the delay picks which comes first
					s_d.seq = SEQ_EN_DLY;
					s_d.brake = !s_q.cfg.enDelay[15];
					timerLoad = 1'b1;
					timerValue = delayMag(s_q.cfg.enDelay);
				end
			end
			SEQ_HOLD:
			begin
				seqPwm = 1'b1;
				if (s_q.sync2[P_CURRENT])
				begin
					s_d.currSeen = 1'b1;
				end
				if (!enable)
				begin
					s_d.seq = SEQ_OFF;
				end
				else if (timerDone && (s_q.currSeen || s_q.sync2[P_CURRENT]))
				begin
					s_d.seq = SEQ_RUN;
					s_d.brake = 1'b0;
					s_d.wireCond = 1'b0;
				end
				else if (timerDone)
				begin
					// brake stays engaged; no release without current
					s_d.seq = SEQ_WIRE_FAIL;
					s_d.wireCond = 1'b1;
				end
			end
			SEQ_EN_DLY:
			begin
				seqPwm = !s_q.cfg.enDelay[15];
				if (!enable)
				begin
					s_d.seq = SEQ_OFF;
					s_d.brake = 1'b1;
				end
				else if (timerDone)
				begin
					s_d.seq = SEQ_RUN;
					s_d.brake = 1'b0;
				end
			end
			SEQ_RUN:
			begin
				seqPwm = 1'b1;
				if (enFall)
				begin
					// ramp and stop-delay count start in the same cycle
					s_d.seq = SEQ_DECEL;
					s_d.decel = 1'b1;
					s_d.abortRate = s_q.cfg.posMode;
					timerLoad = 1'b1;
					timerValue = s_q.cfg.stopDelay;
				end
			end
			SEQ_DECEL:
			begin
				seqPwm = 1'b1;
				if (motorSpeed <= SPEED_W'(s_q.cfg.actVel) || timerDone)
				begin
					// whichever comes first engages the brake
					s_d.seq = SEQ_BRAKE_WAIT;
					s_d.brake = 1'b1;
					timerLoad = 1'b1;
					timerValue = s_q.cfg.respTime;
				end
			end
			SEQ_BRAKE_WAIT:
			begin
				// power held so the brake locks before the stage drops
				seqPwm = !timerDone;
				if (timerDone)
				begin
					s_d.seq = SEQ_OFF;
					s_d.decel = 1'b0;
				end
			end
			SEQ_WIRE_FAIL:
			begin
				// stay put with brake on until the enable is withdrawn
				if (!enable)
				begin
					s_d.seq = SEQ_OFF;
				end
			end
			default:
			begin
				s_d.seq = SEQ_OFF;
				s_d.brake = 1'b1;
			end
		endcase

		// ----------------------------------------------------------------
		// fault gating, pin and log
		// ----------------------------------------------------------------
		// following error keeps the stage running; every other fault cuts it
		s_d.pwm = seqPwm && ((faultActive & ~FOLLOW_MASK) == '0);
		s_d.faultOut = (faultActive & s_q.cfg.outMask) != '0;
		newFaults = faultActive & ~s_q.activePrev & ~FOLLOW_MASK;
		s_d.activePrev = faultActive;
		if (newFaults != '0)
		begin
			s_d.lastCode = faultCode(newFaults);
			if (s_q.logCount != 8'hff)
			begin
				s_d.logCount = s_q.logCount + 8'h01;
			end
		end
	end

	//--------------------------------------------------------------------
	// register
	//--------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_q <= '0;
			s_q.seq <= SEQ_OFF;
			s_q.brake <= 1'b1; // brake engaged from power-up
			s_q.lastCode <= 4'hf; // empty log
			s_q.cfg.stopDelay <= STOP_DLY_RESET;
			s_q.cfg.respTime <= RESP_RESET;
			s_q.cfg.holdTime <= HOLD_RESET;
			s_q.cfg.enDelay <= EN_DLY_RESET;
			s_q.cfg.actVel <= ACT_VEL_RESET;
			s_q.cfg.latchEn <= LATCH_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	//--------------------------------------------------------------------
	// outputs, all straight from flip-flops
	//--------------------------------------------------------------------
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign brake_output_pin = s_q.brake;
	assign pwmEnable = s_q.pwm;
	assign decelActive = s_q.decel;
	assign decelUseAbort = s_q.abortRate;
	assign faultOutPin = s_q.faultOut;
endmodule

//--- design/bsfm_pkg.sv
// package: constants, register map and types of the brake sequencer and fault manager
//------------------------------------------------------------------------------
// Functional notes
// - disable starts decel and stop-delay timer together
// - decel uses abort rate (position) or fast-stop (velocity)
// - brake on at activation speed or delay expiry
// - power stage stays on until response time passes
// - with brake: drive current, hold brake for hold time
// - no current sensed: keep brake, raise wiring fault
// - current sensed: release brake after hold time
// - positive enable delay: pwm first, brake later
// - negative enable delay: brake first, pwm later
// - non-following faults cut pwm and log fault type
// - fault output pin selectable per fault
// - non-latched faults self-clear, pwm returns
// - latched faults clear on clear action once gone
// - six faults latched by default, reconfigurable
// - bus over/under voltage faults track the voltage
// - motor thermal switch fault tracks the switch
// - phasing fault only with sine commutation hall check
// - command input loss fault tracks command presence
// - optional i2t over-current fault, always latched
// - short circuit fault tracks the short
//------------------------------------------------------------------------------
package bsfm_pkg;

	//------------------------------------------------------------------------
	// register map, byte addresses
	//------------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00; // enable, clear and mode bits
	localparam logic [7:0] OFF_STOP_DLY = 8'h04; // brake/stop delay, cycles
	localparam logic [7:0] OFF_RESP = 8'h08; // brake response time, cycles
	localparam logic [7:0] OFF_HOLD = 8'h0c; // brake hold time on enable, cycles
	localparam logic [7:0] OFF_EN_DLY = 8'h10; // signed brake enable delay, cycles
	localparam logic [7:0] OFF_ACT_VEL = 8'h14; // brake activation speed
	localparam logic [7:0] OFF_LATCH = 8'h18; // per-fault latch enables
	localparam logic [7:0] OFF_OUT_MASK = 8'h1c; // faults routed to the fault pin
	localparam logic [7:0] OFF_STATUS = 8'h20; // active faults and sequencer state
	localparam logic [7:0] OFF_LOG = 8'h24; // last fault code and count

	//------------------------------------------------------------------------
	// control register bits
	//------------------------------------------------------------------------
	localparam int CTRL_SW_EN = 0;
	localparam int CTRL_CLEAR = 1;
	localparam int CTRL_POS_MODE = 2;
	localparam int CTRL_BRAKE_USED = 3;
	localparam int CTRL_SINE_HALL = 4;
	localparam int CTRL_I2T_EN = 5;
	localparam int CTRL_EN_CLEARS = 6;

	//------------------------------------------------------------------------
	// fault indices
	//------------------------------------------------------------------------
	localparam int NUM_FAULTS = 11;
	localparam int F_SHORT = 0;
	localparam int F_AMP_OT = 1;
	localparam int F_MOTOR_OT = 2;
	localparam int F_OVER_V = 3;
	localparam int F_UNDER_V = 4;
	localparam int F_FEEDBACK = 5;
	localparam int F_PHASING = 6;
	localparam int F_FOLLOW = 7;
	localparam int F_CMD = 8;
	localparam int F_WIRING = 9;
	localparam int F_OVER_CUR = 10;
	localparam logic [NUM_FAULTS-1:0] LATCH_RESET = 11'h4a7;
	localparam logic [NUM_FAULTS-1:0] FOLLOW_MASK = 11'h080;
	localparam logic [NUM_FAULTS-1:0] OVER_CUR_MASK = 11'h400;

	//------------------------------------------------------------------------
	// synchronised pin indices
	//------------------------------------------------------------------------
	localparam int NUM_PINS = 8;
	localparam int P_HW_EN = 0;
	localparam int P_THERMAL = 1;
	localparam int P_SHORT = 2;
	localparam int P_AMP_OT = 3;
	localparam int P_FEEDBACK = 4;
	localparam int P_OVER_V = 5;
	localparam int P_UNDER_V = 6;
	localparam int P_CURRENT = 7;

	//------------------------------------------------------------------------
	// timing and reset values
	//------------------------------------------------------------------------
	localparam int TIMER_W = 16;
	localparam logic [15:0] STOP_DLY_RESET = 16'h0100;
	localparam logic [15:0] RESP_RESET = 16'h0040;
	localparam logic [15:0] HOLD_RESET = 16'h0080;
	localparam logic [15:0] EN_DLY_RESET = 16'h0000;
	localparam logic [15:0] ACT_VEL_RESET = 16'h0010;

	// sequencer states
	typedef enum logic [2:0] {
		SEQ_OFF = 3'b000,
		SEQ_HOLD = 3'b001,
		SEQ_EN_DLY = 3'b010,
		SEQ_RUN = 3'b011,
		SEQ_DECEL = 3'b100,
		SEQ_BRAKE_WAIT = 3'b101,
		SEQ_WIRE_FAIL = 3'b110
	} bsfm_seq_type;

	// software configuration
	typedef struct packed {
		logic swEnable;
		logic posMode;
		logic brakeUsed;
		logic sineHall;
		logic i2tEnable;
		logic enableClears;
		logic [15:0] stopDelay;
		logic [15:0] respTime;
		logic [15:0] holdTime;
		logic [15:0] enDelay;
		logic [15:0] actVel;
		logic [NUM_FAULTS-1:0] latchEn;
		logic [NUM_FAULTS-1:0] outMask;
	} bsfm_cfg_type;

endpackage

//--- design/bsfm_timer.sv
// module: down counter that times the brake sequencer delays
`timescale 1ns/100ps
module bsfm_timer
	import bsfm_pkg::*;
#(
	parameter int W = TIMER_W
)(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [W-1:0] loadValue,
	output logic expired
);
	//--------------------------------------------------------------------
	// state
	//--------------------------------------------------------------------
	typedef struct packed {
		logic running; // a delay is in progress
		logic [W-1:0] count; // cycles left
	} bsfm_timer_state_type;

	bsfm_timer_state_type s_q; // registered state
	bsfm_timer_state_type s_d; // next state

	// count down; a load restarts the delay and overrides expiry
	always_comb
	begin
		s_d = s_q;
		if (load)
		begin
			s_d.running = 1'b1;
			s_d.count = loadValue;
		end
		else if (s_q.running && s_q.count != '0)
		begin
			s_d.count = s_q.count - 1'b1;
		end
	end

	// level stays high until the next load
	assign expired = s_q.running && s_q.count == '0;

	// register
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end
endmodule

//--- design/bsfm_fault_latch.sv
// module: per-fault active flags with latched or self-clearing behaviour
`timescale 1ns/100ps
module bsfm_fault_latch
	import bsfm_pkg::*;
#(
	parameter int N = NUM_FAULTS
)(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [N-1:0] cond,
	input wire logic [N-1:0] latchEn,
	input wire logic clearEvt,
	output logic [N-1:0] active
);
	//--------------------------------------------------------------------
	// state
	//--------------------------------------------------------------------
	logic [N-1:0] active_q; // fault flags
	logic [N-1:0] active_d; // next flags

	// a present condition always wins over a clear, so nothing is lost
	always_comb
	begin
		active_d = cond | (active_q & latchEn & {N{~clearEvt}});
	end

	assign active = active_q;

	// register; power cycle of the logic supply clears every flag
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			active_q <= '0;
		end
		else
		begin
			active_q <= active_d;
		end
	end
endmodule

//--- test/bsfm_assertions.sv
// checker: bus timing and fault gating at the block ports
`timescale 1ns/100ps
module bsfm_assertions(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic shortDetectPin,
	input wire logic overVoltagePin,
	input wire logic commandLost,
	input wire logic pwmEnable,
	input wire logic decelActive,
	input wire logic brake_output_pin,
	input wire logic faultOutPin
);
	//--------------------------------------------------------------
	// bus answer
	//--------------------------------------------------------------
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	pready_setup_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	pready_once_a: assert property (pready |=> !pready)
		else $error("answer held");
	slverr_ready_a: assert property (pslverr |-> pready)
		else $error("error without answer");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	//--------------------------------------------------------------
	// power stage gating, pins pass two sync flops first
	//--------------------------------------------------------------
	short_cut_a: assert property (shortDetectPin [*5] |-> !pwmEnable)
		else $error("power on during short");
	volt_cut_a: assert property (overVoltagePin [*5] |-> !pwmEnable)
		else $error("power on at over voltage");
	cmd_cut_a: assert property (commandLost [*3] |-> !pwmEnable)
		else $error("power on without command");
	cmd_no_rise_a: assert property ($rose(pwmEnable) |-> !$past(commandLost, 2))
		else $error("power rose over a fault");
	stop_ends_a: assert property ($fell(decelActive) |=> !pwmEnable)
		else $error("power left on after stop");
	cover property ($rose(decelActive));
	cover property ($fell(brake_output_pin));
	cover property ($rose(faultOutPin));
endmodule
bind bsfm_top bsfm_assertions chk_u(.*);

//--- test/bsfm_motor.sv
// model: motor windings and load seen from the drive
`timescale 1ns/100ps
module bsfm_motor(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic pwmEnable,
	input wire logic brake_output_pin,
	input wire logic decelActive,
	input wire logic wired,
	output logic currentSensePin,
	output logic [15:0] motorSpeed
);
	// current flows only with power on and leads connected
	assign currentSensePin = pwmEnable & wired;
	// coasts down one unit a cycle while stopping, so the speed branch is slow
	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn)
			motorSpeed <= 16'h0;
		else if (decelActive)
			motorSpeed <= motorSpeed - {15'h0, |motorSpeed};
		else if (pwmEnable & !brake_output_pin)
			motorSpeed <= 16'h0100;
endmodule

//--- test/bsfm_top_test.sv
// bench: enable, stop and fault runs of the brake sequencer
`timescale 1ns/100ps
module bsfm_top_test;
	import bsfm_pkg::*;
	logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, cs, brk, pwm;
	logic dec, abrt, fpin, wired, hw, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, ctrl;
	logic [10:0] cond;
	logic [15:0] spd;
	logic [31:0] rv [8] = '{0, 32'h100, 32'h40, 32'h80, 0, 32'h10, 32'h4a7, 0};
	int bad_count, comparisons, n, d, resp, sd, lv, code;
	bsfm_top dut_u(.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .hwEnablePin(hw), .thermalSwitchPin(cond[F_MOTOR_OT]),
		.shortDetectPin(cond[F_SHORT]), .ampOverTempPin(cond[F_AMP_OT]),
		.feedbackErrorPin(cond[F_FEEDBACK]), .overVoltagePin(cond[F_OVER_V]),
		.underVoltagePin(cond[F_UNDER_V]), .currentSensePin(cs),
		.hallMismatch(cond[F_PHASING]), .commandLost(cond[F_CMD]),
		.i2tLimitReached(cond[F_OVER_CUR]), .followingError(cond[F_FOLLOW]),
		.motorSpeed(spd), .brake_output_pin(brk), .pwmEnable(pwm), .decelActive(dec),
		.decelUseAbort(abrt), .faultOutPin(fpin));
	bsfm_motor motor_u(.ref_clk, .resetn, .pwmEnable(pwm), .brake_output_pin(brk),
		.decelActive(dec), .wired, .currentSensePin(cs), .motorSpeed(spd));
	initial
	begin
		ref_clk = 0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// watchdog, far past the longest run
	initial
	begin
		repeat (40000) @(posedge ref_clk);
		bad_count++;
		end_of_test();
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] a, input logic [31:0] e);
		comparisons++;
		if (a !== e)
		begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", s, e, a);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1;
		do
		begin
			@(posedge ref_clk);
		end
		while (pready !== 1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wv(ref logic s, input logic v);
		n = 0;
		while (s !== v && n < 3000)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 3000)
			bad_count++;
	endtask
	task automatic pwr();
		resetn <= 0;
		repeat (4) @(posedge ref_clk);
		resetn <= 1;
	endtask
	// enable, then time the second output from the first
	task automatic go(ref logic a, input logic va, ref logic b, input int t);
		apb(1, OFF_CTRL, ctrl | 1);
		wv(a, va);
		chk("order", b, va);
		wv(b, !va);
		chk("delay", n >= t - 1 && n <= t + 4, 1);
	endtask
	// speed 0x100 falls one a cycle, reaching 0x10 after 240
	function automatic int bt(int s);
		return s < 240 ? s : 240;
	endfunction
	function automatic logic lat(int i);
		return lv[i] || i == F_OVER_CUR;
	endfunction
	task automatic stop();
		apb(1, OFF_CTRL, ctrl);
		wv(dec, 1);
		chk("decel", n <= 3, 1);
		chk("rate", abrt, ctrl[CTRL_POS_MODE]);
		wv(brk, 1);
		chk("brake", n + 3 >= bt(sd) && n <= bt(sd) + 4, 1);
		wv(pwm, 0);
		chk("resp", n >= resp - 1 && n <= resp + 4, 1);
		repeat (3) @(posedge ref_clk);
	endtask
	//--------------------------------------------------------------
	// main sequence
	//--------------------------------------------------------------
	initial
	begin
		{resetn, psel, penable, pwrite, hw, paddr, pwdata, cond} = '0;
		wired = 1;
		void'($urandom(26137));
		pwr();
		for (int i = 0; i < 8; i++)
		begin
			apb(0, 8'(4 * i), 0);
			chk("reset value", rd, rv[i]);
		end
		apb(0, 8'h40, 0);
		chk("unmapped", err, 1);
		$display("registers done");
		// both signs of enable delay, stop by speed
		for (int i = 0; i < 2; i++)
		begin
			d = 5 + $urandom % 30;
			resp = 10 + $urandom % 30;
			sd = 256;
			ctrl = i << 2;
			apb(1, OFF_RESP, resp);
			apb(1, OFF_EN_DLY, i ? -d : d);
			if (i)
				go(brk, 0, pwm, d);
			else
				go(pwm, 1, brk, d);
			stop();
		end
		// wiring check passes, stop by delay expiry
		d = 10 + $urandom % 40;
		sd = 20 + $urandom % 40;
		ctrl = 32'hc;
		apb(1, OFF_HOLD, d);
		apb(1, OFF_STOP_DLY, sd);
		go(pwm, 1, brk, d);
		stop();
		// motor left open: brake kept, fault raised
		wired <= 0;
		apb(1, OFF_CTRL, 32'h9);
		repeat (d + 20) @(posedge ref_clk);
		apb(0, OFF_STATUS, 0);
		chk("open motor", {brk, rd[F_WIRING]}, 2'b11);
		pwr();
		wired <= 1;
		apb(0, OFF_STATUS, 0);
		chk("power cycle", rd[10:0], 0);
		apb(0, OFF_LOG, 0);
		chk("log reset", rd[15:0], 16'h000f);
		$display("sequencer done");
		// each fault except wiring raised, dropped, cleared
		lv = $urandom % 2048;
		code = 15;
		apb(1, OFF_LATCH, lv);
		apb(1, OFF_OUT_MASK, 32'h7ff);
		apb(1, OFF_CTRL, 32'h71);
		repeat (9) @(posedge ref_clk);
		for (int i = 0; i < NUM_FAULTS; i++)
		begin
			if (i == F_WIRING)
				continue;
			cond[i] <= 1;
			repeat (6) @(posedge ref_clk);
			chk("cut", {pwm, fpin}, {i == F_FOLLOW, 1'b1});
			cond[i] <= 0;
			repeat (6) @(posedge ref_clk);
			chk("held", {pwm, fpin}, {!lat(i) || i == F_FOLLOW, lat(i)});
			apb(0, OFF_LOG, 0);
			if (i != F_FOLLOW)
				code = i;
			chk("log", rd[3:0], code);
			// odd faults cleared by a pulse on the hardware enable
			if (i % 2)
			begin
				hw <= 1;
				@(posedge ref_clk);
				hw <= 0;
			end
			else
				apb(1, OFF_CTRL, 32'h73);
			repeat (6) @(posedge ref_clk);
			chk("clear", {pwm, fpin}, 2'b10);
		end
		$display("faults done");
		end_of_test();
	end
endmodule
